//--- hw/bififo_parity.sv
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bififo_parity #(
    parameter int DEPTH = bififo_pkg::DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire bififo_pkg::port_in_t  port_a_in,
    input  wire bififo_pkg::port_in_t  port_b_in,
    output bififo_pkg::port_out_t      port_a_out,
    output bififo_pkg::port_out_t      port_b_out,
    output logic                       mail1_full_n,
    output logic                       mail2_full_n
);
    localparam int W = bififo_pkg::WORD_W;

    typedef struct packed {
        logic                odd;
        logic                wr_pend;
        logic [31:0]         addr;
        logic [31:0]         hrdata;
        logic                hready;
        logic [1:0][W-1:0]   fifo_out;
        logic [1:0][W-1:0]   dout;
        logic [1:0][W-1:0]   mail;
        logic [1:0]          oe_n;
        logic [1:0]          perr_n;
        logic [1:0]          mail_full_n;
        logic [1:0][AW:0]    wptr;
        logic [1:0][AW:0]    rptr;
    } state_t;

    state_t               q;
    state_t               d;
    logic     [W-1:0]     mem [2][DEPTH];
    bififo_pkg::port_in_t pin [2];
    logic     [W-1:0]     rd_word [2];
    logic     [W-1:0]     fgen [2];
    logic     [W-1:0]     tree_in [2];
    logic     [W-1:0]     tgen [2];
    logic     [1:0]       terr;
    logic     [1:0]       empty;
    logic     [1:0]       full;
    logic     [1:0]       wr_fifo;
    logic     [1:0]       rd_fifo;
    logic     [1:0]       wr_mail;
    logic     [1:0]       rd_mail;
    logic     [1:0]       mgen;
    logic     [1:0]       rd_sel;
    logic                 bus_act;

    assign pin[0]  = port_a_in;
    assign pin[1]  = port_b_in;
    assign bus_act = hsel && hready && htrans[bififo_pkg::HTRANS_ACT];

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic act;
        assign act        = !pin[p].chip_sel_n && pin[p].port_en;
        assign rd_sel[p]  = act && !pin[p].dir_sel;
        assign empty[p]   = q.wptr[p] == q.rptr[p];
        assign full[p]    = (q.wptr[p][AW] != q.rptr[p][AW])
                            && (q.wptr[p][AW-1:0] == q.rptr[p][AW-1:0]);
        assign wr_fifo[p] = act && pin[p].dir_sel && !pin[p].mailbox_sel && !full[p];
        assign rd_fifo[p] = rd_sel[p] && !pin[p].mailbox_sel && !empty[1-p];
        assign wr_mail[p] = act && pin[p].dir_sel && pin[p].mailbox_sel && q.mail_full_n[p];
        assign rd_mail[p] = rd_sel[p] && pin[p].mailbox_sel;
        assign mgen[p]    = rd_mail[p] && pin[p].gen_sel; // [R9]
        assign rd_word[p] = mem[1-p][q.rptr[1-p][AW-1:0]];
        // The port's own check trees are borrowed for the mailbox it reads. [R8]
        assign tree_in[p] = mgen[p] ? q.mail[1-p] : pin[p].data;

        lane_parity u_fifo_gen (
            .data (rd_word[p]),
            .odd  (q.odd),
            .gen  (fgen[p]),
            .err  ()
        );

        lane_parity u_tree (
            .data (tree_in[p]),
            .odd  (q.odd),
            .gen  (tgen[p]),
            .err  (terr[p])
        );
    end

    always_comb begin
        d         = q;
        d.hready  = 1'b1;
        d.wr_pend = bus_act && hwrite;
        if (bus_act) begin
            d.addr = haddr;
        end
        if (q.wr_pend && q.addr == bififo_pkg::CTRL_OFS) begin
            d.odd = hwdata[bififo_pkg::CTRL_ODD_BIT];
        end
        if (bus_act && !hwrite) begin
            if (haddr == bififo_pkg::CTRL_OFS) begin
                d.hrdata = {31'h0000_0000, d.odd};
            end else if (haddr == bififo_pkg::STAT_OFS) begin
                d.hrdata = {24'h00_0000, full[1], empty[1], full[0], empty[0],
                            q.perr_n[1], q.perr_n[0], q.mail_full_n[1], q.mail_full_n[0]};
            end else begin
                d.hrdata = 32'h0000_0000;
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (wr_fifo[p]) begin
                d.wptr[p] = q.wptr[p] + 1'b1;
            end
            if (rd_fifo[p]) begin
                d.rptr[1-p] = q.rptr[1-p] + 1'b1;
                // Selects are sampled only at the edge loading a new word. [R7]
                d.fifo_out[p] = pin[p].gen_sel ? fgen[p] : rd_word[p]; // [R1] [R5] [R6] [R14]
            end
            if (rd_mail[1-p]) begin
                d.mail_full_n[p] = 1'b1;
            end
            if (wr_mail[p]) begin
                d.mail[p]        = pin[p].data; // [R3]
                d.mail_full_n[p] = 1'b0;
            end
            // Mailbox parity only reaches the driven word. [R10] [R12]
            d.dout[p]   = pin[p].mailbox_sel ? (mgen[p] ? tgen[p] : q.mail[1-p])
                                             : d.fifo_out[p];
            d.oe_n[p]   = !(!pin[p].chip_sel_n && !pin[p].dir_sel);
            d.perr_n[p] = mgen[p] ? 1'b1 : !terr[p]; // [R11]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q             <= '0;
            q.odd         <= bififo_pkg::CTRL_ODD_RST;
            q.hready      <= 1'b1;
            q.oe_n        <= 2'b11;
            q.perr_n      <= 2'b11;
            q.mail_full_n <= 2'b11;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge hclk) begin
        for (int p = 0; p < 2; p++) begin
            if (wr_fifo[p]) begin
                mem[p][q.wptr[p][AW-1:0]] <= pin[p].data; // [R3]
            end
        end
    end

    assign hrdata       = q.hrdata;
    assign hreadyout    = q.hready;
    assign hresp        = 1'b0;
    assign mail1_full_n = q.mail_full_n[0];
    assign mail2_full_n = q.mail_full_n[1];
    assign port_a_out   = '{data: q.dout[0], data_oe_n: q.oe_n[0], perr_n: q.perr_n[0]};
    assign port_b_out   = '{data: q.dout[1], data_oe_n: q.oe_n[1], perr_n: q.perr_n[1]};

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    for (genvar p = 0; p < 2; p++) begin : g_chk
        property p_fifo_gen;
            rd_fifo[p] && pin[p].gen_sel |=>
                bififo_pkg::lane_ones(q.fifo_out[p]) == {bififo_pkg::LANES{$past(q.odd)}};
        endproperty
        a_fifo_gen: assert property (p_fifo_gen) else $error("fifo parity sense wrong"); // [R13]

        property p_fifo_pass;
            rd_fifo[p] && pin[p].gen_sel |=>
                (q.fifo_out[p] & bififo_pkg::DATA_MASK)
                == ($past(rd_word[p]) & bififo_pkg::DATA_MASK);
        endproperty
        a_fifo_pass: assert property (p_fifo_pass) else $error("fifo data bits altered"); // [R5]

        property p_fifo_raw;
            rd_fifo[p] && !pin[p].gen_sel |=> q.fifo_out[p] == $past(rd_word[p]);
        endproperty
        a_fifo_raw: assert property (p_fifo_raw) else $error("raw fifo read altered"); // [R14]

        property p_fifo_hold;
            !rd_fifo[p] |=> $stable(q.fifo_out[p]);
        endproperty
        a_fifo_hold: assert property (p_fifo_hold) else $error("fifo output reg moved"); // [R6]

        property p_store;
            wr_fifo[p] |=> mem[p][$past(q.wptr[p][AW-1:0])] == $past(pin[p].data);
        endproperty
        a_store: assert property (p_store) else $error("fifo write not stored"); // [R3]

        property p_mail_gen;
            mgen[p] |=> bififo_pkg::lane_ones(q.dout[p]) == {bififo_pkg::LANES{$past(q.odd)}}
                        && q.perr_n[p];
        endproperty
        a_mail_gen: assert property (p_mail_gen) else $error("mailbox parity wrong"); // [R8]

        property p_mail_keep;
            rd_mail[p] && !wr_mail[1-p] |=> $stable(q.mail[1-p]);
        endproperty
        a_mail_keep: assert property (p_mail_keep) else $error("mailbox changed by read"); // [R10]

        property p_perr_force;
            mgen[p] |=> q.perr_n[p] == 1'b1;
        endproperty
        a_perr_force: assert property (p_perr_force) else $error("parity flag not forced"); // [R11]

        property p_src;
            !pin[p].mailbox_sel |=> q.dout[p] == q.fifo_out[p];
        endproperty
        a_src: assert property (p_src) else $error("output not from fifo register"); // [R12]
    end
endmodule

//--- hw/bififo_pkg.sv
// Overview of operation
// [R1] A high generate select makes a port's reads carry generated parity, from FIFO or mailbox.
// [R2] A 36-bit word is four 9-bit lanes whose top bit is the lane parity bit.
// [R3] Every write into a FIFO or a mailbox stores all 36 input bits whatever the selects are.
// [R4] A generated bit is computed from its lane's lower eight bits in the selected sense only.
// [R5] Generated bits replace each lane's stored top bit while the other 32 bits pass unchanged.
// [R6] FIFO parity is made on the word leaving storage and registered with it in the output register.
// [R7] The outside party keeps generate and sense selects stable at the edge that loads a FIFO word.
// [R8] Mail-1 parity uses the port-B input check trees and mail-2 parity the port-A trees.
// [R9] Mailbox generation needs read direction, mailbox select, chip select low, enable and generate.
// [R10] Generating mailbox parity changes only the driven bits, never the stored mailbox word.
// [R11] A mailbox read with generation forces that port's active-low parity error flag high.
// [R12] Driven data comes from the FIFO output register with mailbox select low, else the mailbox.
// [R13] Odd sense makes each nine-bit lane hold an odd count of ones, even sense an even count.
// [R14] With generate select low a read returns all 36 stored bits exactly as written.
package bififo_pkg;
    localparam int          WORD_W       = 36;
    localparam int          LANES        = 4;
    localparam int          LANE_W       = 9;
    localparam int          DEPTH        = 64;
    localparam logic [31:0] CTRL_OFS     = 32'h0000_0000;
    localparam logic [31:0] STAT_OFS     = 32'h0000_0004;
    localparam int          CTRL_ODD_BIT = 0;
    localparam logic        CTRL_ODD_RST = 1'b1;
    localparam int          HTRANS_ACT   = 1;
    localparam logic [35:0] DATA_MASK    = 36'h7fbfdfeff;

    typedef struct packed {
        logic              chip_sel_n;
        logic              port_en;
        logic              dir_sel;
        logic              mailbox_sel;
        logic              gen_sel;
        logic [WORD_W-1:0] data;
    } port_in_t;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic              data_oe_n;
        logic              perr_n;
    } port_out_t;

    function automatic logic [LANES-1:0] lane_ones(input logic [WORD_W-1:0] w);
        logic [LANES-1:0] r;
        r = '0;
        for (int l = 0; l < LANES; l++) begin
            r[l] = ^w[l*LANE_W +: LANE_W];
        end
        return r;
    endfunction
endpackage

//--- hw/lane_parity.sv
`timescale 1ns/1ps
module lane_parity #(
    parameter int LANES  = bififo_pkg::LANES,
    parameter int LANE_W = bififo_pkg::LANE_W
) (
    input  wire logic [LANES*LANE_W-1:0] data,
    input  wire logic                    odd,
    output logic      [LANES*LANE_W-1:0] gen,
    output logic                         err
);
    logic [LANES-1:0] lane_err;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W-2:0] low;
        assign low = data[l*LANE_W +: LANE_W-1];
        // Parity from the lower bits only, placed in the lane's top bit. [R2] [R4] [R13]
        assign gen[l*LANE_W +: LANE_W] = {(^low) ^ odd, low};
        assign lane_err[l] = (^data[l*LANE_W +: LANE_W]) != odd;
    end

    assign err = |lane_err;
endmodule

//--- tb/port_host.sv
`timescale 1ns/1ps
// Synchronous processor on one port; each op is one access, then the port is released.
module port_host (
    input  wire logic     clk,
    output bififo_pkg::port_in_t pin
);
    initial begin
        pin            = '0;
        pin.chip_sel_n = 1'b1;
    end

    task automatic op(input logic dir, input logic mb, input logic gen, input logic [35:0] d);
        @(posedge clk);
        pin.chip_sel_n  <= 1'b0;
        pin.port_en     <= 1'b1;
        pin.dir_sel     <= dir;
        pin.mailbox_sel <= mb;
        pin.gen_sel     <= gen;
        pin.data        <= d;
        @(posedge clk);
        // Direction, mailbox and generate selects stay put after the loading edge; chip select is released and the data bus changes.
        pin.chip_sel_n  <= 1'b1;
        pin.data        <= ~d;
    endtask
endmodule

//--- tb/read_port_parity_generator_tb.sv
`timescale 1ns/1ps
module read_port_parity_generator_tb;
    logic                  hclk;
    logic                  hresetn;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
    bififo_pkg::port_in_t  port_a_in;
    bififo_pkg::port_in_t  port_b_in;
    bififo_pkg::port_out_t port_a_out;
    bififo_pkg::port_out_t port_b_out;
    int                    num_errors;
    int                    check_count;
    int                    cyc;
    int                    seed;
    logic [31:0]           rd;
    logic [35:0]           mdl[$];
    logic [35:0]           wv;
    logic [35:0]           ev;
    logic                  mail1_full_n;
    logic                  mail2_full_n;

    bififo_parity #(.DEPTH(4)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_a_in(port_a_in), .port_b_in(port_b_in), .port_a_out(port_a_out),
        .port_b_out(port_b_out), .mail1_full_n(mail1_full_n), .mail2_full_n(mail2_full_n)
    );
    port_host u_pa (.clk(hclk), .pin(port_a_in));
    port_host u_pb (.clk(hclk), .pin(port_b_in));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Each lane's top bit set so the nine-bit lane has the chosen ones count.
    function automatic logic [35:0] lane_fix(input logic [35:0] w, input logic odd);
        logic [35:0] r;
        r = w;
        for (int l = 0; l < 4; l++) r[l*9+8] = (^w[l*9 +: 8]) ^ odd;
        return r;
    endfunction

    // High when every nine-bit lane holds the ones count that the sense asks for.
    function automatic logic perr_exp(input logic [35:0] w, input logic odd);
        logic bad;
        bad = 1'b0;
        for (int l = 0; l < 4; l++) bad = bad | ((^w[l*9 +: 9]) != odd);
        return !bad;
    endfunction

    task automatic xfer(input logic a2b, input logic mb, input logic g, input logic odd);
        logic [35:0] w;
        logic [35:0] e;
        logic [31:0] r;
        r = $random(seed);
        w = {r[3:0], $random(seed)};
        mdl.push_back(w);
        if (a2b) u_pa.op(1'b1, mb, r[4], w);
        else u_pb.op(1'b1, mb, r[4], w);
        #1;
        chk({35'h0, a2b ? mail1_full_n : mail2_full_n}, {35'h0, !mb});
        chk({35'h0, a2b ? port_a_out.data_oe_n : port_b_out.data_oe_n}, 36'h1);
        chk({35'h0, a2b ? port_a_out.perr_n : port_b_out.perr_n}, {35'h0, perr_exp(w, odd)});
        w = mdl.pop_front();
        e = g ? lane_fix(w, odd) : w;
        if (a2b) u_pb.op(1'b0, mb, g, ~w);
        else u_pa.op(1'b0, mb, g, ~w);
        #1;
        chk(a2b ? port_b_out.data : port_a_out.data, e);
        if (mb && g) chk({35'h0, a2b ? port_b_out.perr_n : port_a_out.perr_n}, 36'h1);
        chk({35'h0, a2b ? port_b_out.data_oe_n : port_a_out.data_oe_n}, 36'h0);
        chk({35'h0, a2b ? mail1_full_n : mail2_full_n}, 36'h1);
        // A second plain read: the mailbox word is intact, an empty FIFO keeps its word.
        if (a2b) u_pb.op(1'b0, mb, 1'b0, w);
        else u_pa.op(1'b0, mb, 1'b0, w);
        #1;
        chk(a2b ? port_b_out.data : port_a_out.data, mb ? w : e);
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        seed        = 32'hed98;
        num_errors  = 0;
        check_count = 0;
        cyc         = 0;
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hwdata      = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, bififo_pkg::CTRL_OFS, 32'h0);
        chk({4'h0, rd}, 36'h1);
        chk({35'h0, hresp}, 36'h0);
        ahb(1'b0, 32'h0000_0010, 32'h0);
        chk({4'h0, rd}, 36'h0);
        for (int i = 0; i < 16; i++) begin
            ahb(1'b1, bififo_pkg::CTRL_OFS, {31'h0, i[3]});
            xfer(i[0], i[1], i[2], i[3]);
        end
        // Fill the A-to-B FIFO one word past its depth; the extra write is refused.
        for (int k = 0; k < 5; k++) begin
            wv = {k[3:0], $random(seed)};
            if (k < 4) mdl.push_back(wv);
            u_pa.op(1'b1, 1'b0, 1'b0, wv);
        end
        ahb(1'b0, bififo_pkg::STAT_OFS, 32'h0);
        chk({4'h0, rd & 32'h0000_0030}, 36'h20);
        ev = 36'h0;
        for (int k = 0; k < 5; k++) begin
            u_pb.op(1'b0, 1'b0, 1'b0, 36'h0);
            #1;
            if (k < 4) ev = mdl.pop_front();
            chk(port_b_out.data, ev);
        end
        ahb(1'b0, bififo_pkg::STAT_OFS, 32'h0);
        chk({4'h0, rd & 32'h0000_00f3}, 36'h53);
        give_verdict();
    end
endmodule
